// ### ebc_pkg.sv
// Package for the external bus control block
// Assumes one 100 MHz clock, synchronous active-low reset
package ebc_pkg;
  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 16;
  localparam int          NUM_AREAS     = 4;
  localparam int          STROBE_BIT    = 2;
  localparam int          CLKOUT_BIT    = 7;
  localparam logic [7:0]  MODE0_RESET   = 8'h00;
  localparam logic [3:0]  SWAIT_RESET   = 4'h0;
  localparam logic [19:0] AREA0_LO      = 20'h18000;
  localparam logic [19:0] AREA0_HI      = 20'h3FFFF;
  localparam logic [19:0] AREA0_XLO     = 20'h60000;
  localparam logic [19:0] AREA1_LO      = 20'h10000;
  localparam logic [19:0] AREA1_HI      = 20'h17FFF;
  localparam logic [19:0] AREA2_LO      = 20'h0C000;
  localparam logic [19:0] AREA2_HI      = 20'h0FFFF;
  localparam logic [19:0] AREA3_LO      = 20'h08000;
  localparam logic [19:0] AREA3_HI      = 20'h0BFFF;
  localparam logic [1:0]  CYC_SHORT     = 2'h1;
  localparam logic [1:0]  CYC_LONG      = 2'h2;

  typedef enum logic [1:0]
  {
    EBC_KIND_INTROM,
    EBC_KIND_SPECIAL,
    EBC_KIND_EXT
  } ebc_kind_t;

  typedef enum logic [1:0]
  {
    EBC_OWN_CPU,
    EBC_OWN_DMA,
    EBC_OWN_HOLD
  } ebc_owner_t;
endpackage

// ### ebc_dec_if.sv
// Carrier between the bus controller and its helpers
// Assumes package ebc_pkg is compiled first
interface ebc_dec_if;
  logic [19:0]      addr;
  logic             cpuMode;
  logic [3:0]       selHit;
  ebc_pkg::ebc_kind_t kind;
  logic             holdReq;
  logic             dmaReq;
  logic             cpuReq;
  logic             busIdle;
  ebc_pkg::ebc_owner_t owner;
  modport dec (input addr, cpuMode, output selHit, kind);
  modport arb (input holdReq, dmaReq, cpuReq, busIdle, output owner);
  modport ctl (output addr, cpuMode, holdReq, dmaReq, cpuReq, busIdle,
               input selHit, kind, owner);
endinterface

// ### ebc_area_decode.sv
// Area decoder: chip-select windows and access kind
// Assumes addresses above 0x3FF are internal memory unless in a window
module ebc_area_decode
  import ebc_pkg::*;
(
  ebc_dec_if.dec d
);
  logic [19:0] a;
  assign a = d.addr;
  // Fixed chip-select windows
  always_comb
  begin
    d.selHit[0] = (a >= AREA0_LO && a <= AREA0_HI)
                  || (d.cpuMode && a >= AREA0_XLO);
    d.selHit[1] = (a >= AREA1_LO && a <= AREA1_HI);
    d.selHit[2] = (a >= AREA2_LO && a <= AREA2_HI);
    d.selHit[3] = (a >= AREA3_LO && a <= AREA3_HI);
    if (d.selHit != 4'h0)
      d.kind = EBC_KIND_EXT;
    else if (a < 20'h00400)
      d.kind = EBC_KIND_SPECIAL;
    else
      d.kind = EBC_KIND_INTROM;
  end
endmodule

// ### ebc_arbiter.sv
// Bus ownership arbiter
// Assumes owner may only change while the bus is idle
module ebc_arbiter
  import ebc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  ebc_dec_if.arb   a
);
  // Hold over DMA over CPU, switched between accesses
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      a.owner <= EBC_OWN_CPU;
    else if (a.busIdle)
    begin
      if (a.holdReq)
        a.owner <= EBC_OWN_HOLD;
      else if (a.dmaReq)
        a.owner <= EBC_OWN_DMA;
      else
        a.owner <= EBC_OWN_CPU;
    end
  end
endmodule

// ### ebc_bus_ctrl.sv
// External bus controller top: strobes, waits, hold and clock out
// Assumes requests are synchronous to sys_clk; pins are split into
// input, output and active-low output enable
module ebc_bus_ctrl
  import ebc_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Configuration
  input  wire logic [7:0]          procMode0,
  input  wire logic                protectOk,
  input  wire logic                modeWrite,
  input  wire logic [3:0]          swaitBits,
  input  wire logic                widthSelectPin,
  input  wire logic                cpuMode,
  // Access requests
  input  wire logic                cpuReq,
  input  wire logic                dmaReq,
  input  wire logic [19:0]         reqAddr,
  input  wire logic                reqWrite,
  input  wire logic [1:0]          reqBytes,
  input  wire logic [15:0]         reqWdata,
  output      logic                accDone,
  output      logic [15:0]         accRdata,
  output      ebc_pkg::ebc_owner_t busOwner,
  // External pins
  input  wire logic                waitRequest_n,
  input  wire logic                holdRequest_n,
  output      logic                readStrobe_n,
  output      logic                writeStrobe_n,
  output      logic                low_byte_write_n,
  output      logic                high_byte_write_n,
  output      logic                high_byte_enable_n,
  output      logic [19:0]         addrOut,
  input  wire logic [15:0]         dataIn,
  output      logic [15:0]         dataOut,
  output      logic                dataOe_n,
  output      logic                ctrlOe_n,
  output      logic [3:0]          areaSelect_n,
  output      logic                bus_grant_ack_n,
  output      logic                addressLatchPulse,
  output      logic                busClockOut,
  output      logic                busClockOe_n,
  output      logic                watchdogStop
);
  import ebc_pkg::*;

  // Functional notes
  // - Mode bit 2 picks strobe style at 16-bit
  // - Reset selects combined read/write/enable style
  // - Split style: read, even, odd, both writes
  // - Combined style: enable plus A0 select bytes
  // - Address latch pulse has no defined meaning
  // - Wait request sampled each falling clock edge
  // - Wait request honoured only when area bit zero
  // - Wait freezes strobes, address, data, selects
  // - No wait accepted just before software wait
  // - Hold after current access, ack while low
  // - Priority: hold, then DMA, then CPU
  // - Hold floats bus pins, stops watchdog
  // - Special area: address out, selects high
  // - Internal memory: keep address and enable
  // - Mode bit 7 high floats clock output
  // - Area bit one: one cycle, zero: two
  // - All software-wait bits reset to zero
  // - Special two cycles, internal memory one
  // - Four fixed chip-select address windows

  //--------------------------------------------------
  // Configuration registers
  //--------------------------------------------------
  logic       splitStyle;
  logic       clockOutOff;
  logic [3:0] swait;
  logic       wide;

  assign wide = !widthSelectPin;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      splitStyle  <= MODE0_RESET[STROBE_BIT];
      clockOutOff <= MODE0_RESET[CLKOUT_BIT];
    end
    else if (modeWrite && protectOk)
    begin
      splitStyle  <= procMode0[STROBE_BIT] && wide;
      clockOutOff <= procMode0[CLKOUT_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      swait <= SWAIT_RESET;
    else
      swait <= swaitBits;
  end

  //--------------------------------------------------
  // Decode and arbitration
  //--------------------------------------------------
  ebc_dec_if dif ();
  logic busy;
  logic holdReq;

  assign holdReq     = !holdRequest_n;
  assign dif.addr    = reqAddr;
  assign dif.cpuMode = cpuMode;
  assign dif.holdReq = holdReq;
  assign dif.dmaReq  = dmaReq;
  assign dif.cpuReq  = cpuReq;
  assign dif.busIdle = !busy;
  assign busOwner    = dif.owner;

  ebc_area_decode u_dec
  (
    .d (dif.dec)
  );

  ebc_arbiter u_arb
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .a       (dif.arb)
  );

  //--------------------------------------------------
  // Bus cycle sequencer
  //--------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_ACCESS,
    ST_WAIT
  } ebc_state_t;

  ebc_state_t state;
  logic [1:0] cycLeft;
  ebc_kind_t  curKind;
  logic       curWrite;
  logic [3:0] curSel;
  logic       waitOk;
  logic       waitSeen;
  logic       start;
  logic [1:0] next_cycles;

  assign start = (state == ST_IDLE) && (dif.owner != EBC_OWN_HOLD)
                 && !holdReq
                 && ((dif.owner == EBC_OWN_DMA) ? dmaReq : cpuReq);
  assign busy  = (state != ST_IDLE);

  // Cycle length per area
  always_comb
  begin
    case (dif.kind)
      EBC_KIND_SPECIAL: next_cycles = CYC_LONG;
      EBC_KIND_INTROM:  next_cycles = CYC_SHORT;
      EBC_KIND_EXT:
        next_cycles = ((swait & dif.selHit) != 4'h0)
                      ? CYC_SHORT : CYC_LONG;
      default:          next_cycles = CYC_LONG;
    endcase
  end

  // Wait accepted only in external areas with wait bit zero, not in the
  // cycle right before the inserted software wait
  assign waitOk = (curKind == EBC_KIND_EXT)
                  && ((swait & curSel) == 4'h0)
                  && (cycLeft == CYC_SHORT);

  // Falling-edge sample of the wait request
  always_ff @(negedge sys_clk)
  begin
    if (!rstn)
      waitSeen <= 1'b0;
    else
      waitSeen <= !waitRequest_n;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state    <= ST_IDLE;
      cycLeft  <= 2'h0;
      curKind  <= EBC_KIND_INTROM;
      curWrite <= 1'b0;
      curSel   <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (start)
          begin
            state    <= ST_ACCESS;
            cycLeft  <= next_cycles;
            curKind  <= dif.kind;
            curWrite <= reqWrite;
            curSel   <= dif.selHit;
          end
        ST_ACCESS:
          if (waitOk && waitSeen)
            state <= ST_WAIT;
          else if (cycLeft == CYC_SHORT)
            state <= ST_IDLE;
          else
            cycLeft <= cycLeft - 2'h1;
        ST_WAIT:
          if (!waitSeen)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  assign accDone = busy && (cycLeft == CYC_SHORT)
                   && ((state == ST_WAIT) ? !waitSeen
                                          : !(waitOk && waitSeen));

  //--------------------------------------------------
  // Pin values, frozen while waiting
  //--------------------------------------------------
  logic isExt;
  assign isExt = (dif.kind == EBC_KIND_EXT);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      readStrobe_n       <= 1'b1;
      writeStrobe_n      <= 1'b1;
      low_byte_write_n   <= 1'b1;
      high_byte_write_n  <= 1'b1;
      high_byte_enable_n <= 1'b1;
      addrOut            <= '0;
      dataOut            <= '0;
      dataOe_n           <= 1'b1;
      areaSelect_n       <= 4'hF;
      accRdata           <= '0;
    end
    else if (start)
    begin
      // Read and write strobes exclusive
      readStrobe_n  <= reqWrite;
      writeStrobe_n <= !reqWrite || splitStyle;
      low_byte_write_n  <= !(reqWrite && splitStyle
                             && reqBytes[0]);
      high_byte_write_n <= !(reqWrite && splitStyle
                             && reqBytes[1]);
      if (dif.kind != EBC_KIND_INTROM)
      begin
        addrOut <= reqAddr;
        // Enable low for odd or word access, combined style at 16-bit
        high_byte_enable_n <= !(wide && !splitStyle
                                && reqBytes[1]);
      end
      dataOut      <= reqWdata;
      dataOe_n     <= !reqWrite;
      areaSelect_n <= isExt ? ~dif.selHit : 4'hF;
    end
    else if (accDone)
    begin
      accRdata          <= dataIn;
      readStrobe_n      <= 1'b1;
      writeStrobe_n     <= 1'b1;
      low_byte_write_n  <= 1'b1;
      high_byte_write_n <= 1'b1;
      dataOe_n          <= 1'b1;
      areaSelect_n      <= 4'hF;
    end
  end

  //--------------------------------------------------
  // Hold, clock output, latch pulse
  //--------------------------------------------------
  logic inHold;
  assign inHold = (dif.owner == EBC_OWN_HOLD) && !busy;

  assign bus_grant_ack_n   = !(inHold && holdReq);
  assign ctrlOe_n          = inHold;
  assign watchdogStop      = inHold;
  assign addressLatchPulse = 1'b0;
  assign busClockOut       = sys_clk;
  assign busClockOe_n      = clockOutOff;

  //--------------------------------------------------
  // Checks
  //--------------------------------------------------
  property p_excl;
    @(posedge sys_clk) disable iff (!rstn)
      !readStrobe_n |-> (writeStrobe_n && low_byte_write_n
                         && high_byte_write_n);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write");

  property p_wfreeze;
    @(posedge sys_clk) disable iff (!rstn)
      (state == ST_WAIT) && $past(state == ST_WAIT)
      |-> $stable(addrOut) && $stable(areaSelect_n)
          && $stable(readStrobe_n);
  endproperty
  a_wfreeze: assert property (p_wfreeze) else $error("wait moved");

  property p_short;
    @(posedge sys_clk) disable iff (!rstn)
      start && next_cycles == CYC_SHORT |=> accDone;
  endproperty
  a_short: assert property (p_short) else $error("short cycle");

  property p_long;
    @(posedge sys_clk) disable iff (!rstn)
      start && next_cycles == CYC_LONG && dif.kind != EBC_KIND_EXT
      |=> !accDone ##1 accDone;
  endproperty
  a_long: assert property (p_long) else $error("long cycle");

  property p_nowait;
    @(posedge sys_clk) disable iff (!rstn)
      (state == ST_ACCESS) && ((swait & curSel) != 4'h0)
      |=> state != ST_WAIT;
  endproperty
  a_nowait: assert property (p_nowait) else $error("bad wait");

  property p_ack;
    @(posedge sys_clk) disable iff (!rstn)
      !bus_grant_ack_n |-> holdReq && !busy && ctrlOe_n;
  endproperty
  a_ack: assert property (p_ack) else $error("ack wrong");

  property p_sel;
    @(posedge sys_clk) disable iff (!rstn)
      start && !isExt |=> areaSelect_n == 4'hF;
  endproperty
  a_sel: assert property (p_sel) else $error("select low");

  property p_hold;
    @(posedge sys_clk) disable iff (!rstn)
      holdReq && !busy |-> !start ##1 (dif.owner == EBC_OWN_HOLD);
  endproperty
  a_hold: assert property (p_hold) else $error("start in hold");
endmodule

// ### ebc_ext_partner.sv
// Far side model: external memory, slow-device wait and bus master
// Assumes the controller's pin ports; wait line idles high (pull-up)
module ebc_ext_partner
(
  // Clock and bus pins
  input  wire logic        sys_clk,
  input  wire logic        readStrobe_n,
  input  wire logic        writeStrobe_n,
  input  wire logic        low_byte_write_n,
  input  wire logic        high_byte_write_n,
  input  wire logic        high_byte_enable_n,
  input  wire logic [19:0] addrOut,
  input  wire logic [15:0] dataOut,
  input  wire logic [3:0]  areaSelect_n,
  // Knobs
  input  wire logic        splitStyle,
  input  wire integer      waitCycles,
  input  wire logic        holdCmd,
  // Answers
  output      logic [15:0] dataIn,
  output      logic        waitRequest_n,
  output      logic        holdRequest_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [18:0]];
  logic [15:0] lastData;
  logic [15:0] word;
  logic        wrEven;
  logic        wrOdd;
  logic        active;
  logic        activeD = 1'b0;
  int          waitLeft = 0;

  // Byte lanes per strobe style
  assign wrEven = splitStyle ? !low_byte_write_n
                             : (!writeStrobe_n && !addrOut[0]);
  assign wrOdd  = splitStyle ? !high_byte_write_n
                             : (!writeStrobe_n && !high_byte_enable_n);
  assign active = (areaSelect_n != 4'hF) && (!readStrobe_n || wrEven || wrOdd);
  // External master asks for the bus
  assign holdRequest_n = !holdCmd;

  initial waitRequest_n = 1'b1;

  // Released data bus shows the inverse of the last value
  always @*
  begin
    if (!readStrobe_n && areaSelect_n != 4'hF)
      dataIn = mem.exists(addrOut[19:1]) ? mem[addrOut[19:1]] : 16'h0000;
    else
      dataIn = ~lastData;
  end

  always @(posedge sys_clk)
  begin
    lastData <= dataIn;
    activeD  <= active;
    if (active && (wrEven || wrOdd))
    begin
      word = mem.exists(addrOut[19:1]) ? mem[addrOut[19:1]] : 16'h0000;
      if (wrEven)
        word[7:0] = dataOut[7:0];
      if (wrOdd)
        word[15:8] = dataOut[15:8];
      mem[addrOut[19:1]] = word;
    end
    // Slow device stretches the cycle
    if (active && !activeD && waitCycles > 0)
    begin
      waitRequest_n <= 1'b0;
      waitLeft      <= waitCycles;
    end
    else if (waitLeft > 1)
      waitLeft <= waitLeft - 1;
    else
    begin
      waitRequest_n <= 1'b1;
      waitLeft      <= 0;
    end
  end
endmodule

// ### tb_external_bus_control.sv
// Testbench for the external bus controller
// Assumes ebc_pkg, ebc_dec_if and the design modules are compiled first
module tb_external_bus_control;
  import ebc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int cyc; int kind; logic w; logic cd; logic [2:0] st;
                  logic [3:0] sel; logic [19:0] a; logic [15:0] d;} ebc_note_t;
  logic        sys_clk, rstn, modeWrite, protectOk, widthSelectPin, cpuMode;
  logic        cpuReq, dmaReq, reqWrite, holdCmd, splitStyle, accDone;
  logic        waitRequest_n, holdRequest_n, readStrobe_n, writeStrobe_n;
  logic        low_byte_write_n, high_byte_write_n, high_byte_enable_n;
  logic        dataOe_n, ctrlOe_n, bus_grant_ack_n, busClockOut;
  logic        busClockOe_n, watchdogStop, addressLatchPulse;
  logic [7:0]  procMode0;
  logic [3:0]  swaitBits, areaSelect_n;
  logic [19:0] reqAddr, addrOut, lastExt;
  logic [1:0]  reqBytes;
  logic [15:0] reqWdata, dataIn, dataOut, accRdata;
  logic [15:0] mirror [logic [18:0]];
  logic [19:0] ar [4] = '{20'h18000, 20'h10000, 20'h0C000, 20'h08000};
  ebc_owner_t  busOwner;
  ebc_note_t   notes[$];
  ebc_note_t   m;
  int          waitCycles, numErrors, samplesChecked, cnt;
  int          seed = 32'hBEC1;

  ebc_bus_ctrl DUT (.*);
  ebc_ext_partner PART (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      numErrors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task tick;
    @(posedge sys_clk);
    #1;
  endtask

  task req(input logic [19:0] a, input logic w, input logic [1:0] b,
           input int cyc, input int kind, input logic [3:0] sel);
    ebc_note_t   n;
    logic [15:0] d;
    logic [15:0] x;
    d = $random(seed);
    n = '{cyc, kind, w, (kind == 0) && (w || b == 2'h3),
          splitStyle ? {w, !(w && b[0]), !(w && b[1])} : {w, !w, !b[1]},
          sel, (kind == 2) ? lastExt : a, d};
    n.st[0] = n.st[0] | widthSelectPin;
    if (kind == 0 && !w)
      n.d = mirror[a[19:1]];
    if (kind == 0 && w)
    begin
      x = mirror.exists(a[19:1]) ? mirror[a[19:1]] : 16'h0000;
      if (b[0])
        x[7:0] = d[7:0];
      if (b[1])
        x[15:8] = d[15:8];
      mirror[a[19:1]] = x;
    end
    if (kind != 2)
      lastExt = a;
    notes.push_back(n);
    reqAddr  = a;
    reqWrite = w;
    reqBytes = b;
    reqWdata = d;
    cpuReq   = 1'b1;
  endtask

  task wait_done;
    int k;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (accDone !== 1'b1 && k < 80);
    #1;
    check("access end", k < 80, 1);
  endtask

  task acc(input logic [19:0] a, input logic w, input logic [1:0] b,
           input int cyc, input int kind, input logic [3:0] sel);
    req(a, w, b, cyc, kind, sel);
    wait_done();
    cpuReq = 1'b0;
    dmaReq = 1'b0;
    tick();
  endtask

  task set_mode(input logic [7:0] v, input logic ok);
    procMode0 = v;
    protectOk = ok;
    modeWrite = 1'b1;
    tick();
    modeWrite = 1'b0;
    tick();
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rstn && (cpuReq || dmaReq))
      cnt++;
    if (rstn && accDone === 1'b1 && notes.size() > 0)
    begin
      m = notes.pop_front();
      if (m.cyc != 0)
        check("cycles", cnt, m.cyc);
      check("selects", areaSelect_n, m.sel);
      check("address", addrOut, m.a);
      check("rd and wr", !readStrobe_n && !(writeStrobe_n
            && low_byte_write_n && high_byte_write_n), 0);
      if (m.kind != 2)
        check("strobes", splitStyle ? {readStrobe_n, low_byte_write_n,
              high_byte_write_n} : {readStrobe_n, writeStrobe_n,
              high_byte_enable_n | widthSelectPin}, m.st);
      if (m.w && m.kind != 2)
        check("write data", dataOut, m.d);
      cnt = 0;
      #1;
      if (m.cd && !m.w)
        check("read data", accRdata, m.d);
    end
    else if (rstn && accDone === 1'b1)
      check("unexpected end", 1, 0);
  end

  initial
  begin
    #200us;
    numErrors++;
    stop_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {rstn, modeWrite, protectOk, widthSelectPin, cpuMode} = 5'h00;
    {cpuReq, dmaReq, reqWrite, holdCmd, splitStyle} = 5'h00;
    {reqAddr, lastExt, reqBytes, reqWdata, swaitBits} = '0;
    procMode0 = 8'h04;
    {waitCycles, numErrors, samplesChecked, cnt} = '0;
    repeat (10) tick();
    rstn = 1'b1;
    tick();
    for (int i = 1; i < 4; i++)
    begin
      acc(ar[1] + (i == 2), 1, i[1:0], 3, 0, 4'hD);
      acc(ar[1] + (i == 2), 0, i[1:0], 3, 0, 4'hD);
    end
    $display("test strobes after reset done");
    for (int i = 0; i < 4; i++)
    begin
      swaitBits = 4'h1 << i;
      tick();
      acc(ar[i], 1, 2'h3, 2, 0, ~(4'h1 << i));
      acc(ar[(i + 1) % 4], 1, 2'h3, 3, 0, ~(4'h1 << ((i + 1) % 4)));
    end
    cpuMode = 1'b1;
    acc(20'h60000, 1, 2'h3, 3, 0, 4'hE);
    cpuMode = 1'b0;
    acc(20'h40000, 0, 2'h3, 2, 2, 4'hF);
    acc(20'h00200, 1, 2'h3, 3, 1, 4'hF);
    acc(20'h00200, 0, 2'h3, 3, 1, 4'hF);
    acc(20'h40000, 1, 2'h3, 2, 2, 4'hF);
    $display("test cycle lengths done");
    waitCycles = 3;
    swaitBits = 4'h7;
    tick();
    acc(ar[3], 0, 2'h3, 6, 0, 4'h7);
    swaitBits = 4'hF;
    tick();
    acc(ar[3], 0, 2'h3, 2, 0, 4'h7);
    waitCycles = 0;
    swaitBits = 4'h0;
    $display("test wait input done");
    @(negedge sys_clk);
    check("clock out", {busClockOut, busClockOe_n}, 0);
    tick();
    set_mode(8'h84, 1'b0);
    check("clock enable", busClockOe_n, 0);
    set_mode(8'h84, 1'b1);
    check("clock enable", busClockOe_n, 1);
    splitStyle = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      acc(ar[2] + 2 * (i % 2), 1, 2'h1 + i % 3, 3, 0, 4'hB);
      acc(ar[2] + 2 * (i % 2), 0, 2'h3, 3, 0, 4'hB);
    end
    $display("test split strobes done");
    holdCmd = 1'b1;
    repeat (3) tick();
    check("hold pins", {bus_grant_ack_n, ctrlOe_n, watchdogStop}, 3'h3);
    check("owner", busOwner, EBC_OWN_HOLD);
    req(ar[2], 0, 2'h3, 0, 0, 4'hB);
    notes.push_back(notes[$]);
    dmaReq = 1'b1;
    repeat (4)
    begin
      @(negedge sys_clk);
      check("held off", {accDone, bus_grant_ack_n}, 0);
    end
    tick();
    holdCmd = 1'b0;
    wait_done();
    check("owner", busOwner, EBC_OWN_DMA);
    dmaReq = 1'b0;
    wait_done();
    cpuReq = 1'b0;
    check("grant", bus_grant_ack_n, 1);
    $display("test hold and priority done");
    rstn = 1'b0;
    widthSelectPin = 1'b1;
    splitStyle = 1'b0;
    repeat (2) tick();
    rstn = 1'b1;
    tick();
    set_mode(8'h00, 1'b1);
    acc(ar[1], 1, 2'h1, 3, 0, 4'hD);
    $display("test narrow bus done");
    stop_test();
  end
endmodule
